// File: fdc_pkg.sv
`default_nettype none
package fdc_pkg;
	// Register indices
	localparam logic [7:0] FDC_IDX_ENABLE = 8'h30;
	localparam logic [7:0] FDC_IDX_BASE_HI = 8'h60;
	localparam logic [7:0] FDC_IDX_BASE_LO = 8'h61;
	localparam logic [7:0] FDC_IDX_IRQ = 8'h70;
	localparam logic [7:0] FDC_IDX_DMA = 8'h74;
	localparam logic [7:0] FDC_IDX_MODE = 8'hf0;
	localparam logic [7:0] FDC_IDX_KIND = 8'hf2;
	localparam logic [7:0] FDC_IDX_SELECT = 8'hf4;

	// Field positions
	localparam int FDC_POS_ENABLE = 0;
	localparam int FDC_POS_PWRDN = 7;
	localparam int FDC_POS_FORCE_WP = 4;
	localparam int FDC_POS_IFMODE = 2;
	localparam int FDC_POS_DMA_MODE = 1;
	localparam int FDC_POS_THREE = 0;
	localparam int FDC_POS_RATE_TBL = 3;
	localparam int FDC_POS_DRV_TYPE = 0;

	// Reset values
	localparam logic [7:0] FDC_RST_ENABLE = 8'h01;
	localparam logic [7:0] FDC_RST_BASE_HI = 8'h03;
	localparam logic [7:0] FDC_RST_BASE_LO = 8'hf0;
	localparam logic [3:0] FDC_RST_IRQ = 4'h6;
	localparam logic [2:0] FDC_RST_DMA = 3'h2;
	localparam logic [7:0] FDC_RST_MODE = 8'h0e;
	localparam logic [1:0] FDC_RST_KIND = 2'h3;
	localparam logic [1:0] FDC_RST_RATE_TBL = 2'h0;
	localparam logic [1:0] FDC_RST_DRV_TYPE = 2'h0;

	// Interface personality codes
	typedef enum logic [1:0] {
		FDC_IF_MODEL30 = 2'b00,
		FDC_IF_ALT = 2'b01,
		FDC_IF_RSVD = 2'b10,
		FDC_IF_AT = 2'b11
	} fdc_personality_t;

	// True for every index this bank answers
	function automatic logic fdc_is_mapped(input logic [7:0] a);
		fdc_is_mapped = (a == FDC_IDX_ENABLE) || (a == FDC_IDX_BASE_HI) ||
			(a == FDC_IDX_BASE_LO) || (a == FDC_IDX_IRQ) || (a == FDC_IDX_DMA) ||
			(a == FDC_IDX_MODE) || (a == FDC_IDX_KIND) || (a == FDC_IDX_SELECT);
	endfunction : fdc_is_mapped
endpackage : fdc_pkg
`default_nettype wire

// File: fdc_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
// Stored configuration fields shared by the bank's modules
interface fdc_cfg_if;
	logic enable;
	logic [7:0] base_hi;
	logic [7:0] base_lo;
	logic [3:0] irq;
	logic [2:0] dma;
	logic [7:0] mode;
	logic [1:0] kind;
	logic [1:0] rate_tbl;
	logic [1:0] drv_type;
	modport owner (output enable, base_hi, base_lo, irq, dma, mode, kind, rate_tbl, drv_type);
	modport viewer (input enable, base_hi, base_lo, irq, dma, mode, kind, rate_tbl, drv_type);
endinterface : fdc_cfg_if
`default_nettype wire

// File: fdc_readback.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_readback
	import fdc_pkg::*;
(
	// Stored fields
	fdc_cfg_if.viewer cfg,
	// Read index and value
	input wire logic [7:0] index,
	output logic [7:0] value
);
	import fdc_pkg::*;

	// Reserved bits and unmapped indices read as zero
	always_comb begin
		value = 8'h00;
		if (index == FDC_IDX_ENABLE) begin
			value[FDC_POS_ENABLE] = cfg.enable;
		end else if (index == FDC_IDX_BASE_HI) begin
			value = cfg.base_hi;
		end else if (index == FDC_IDX_BASE_LO) begin
			value = cfg.base_lo;
		end else if (index == FDC_IDX_IRQ) begin
			value = {4'h0, cfg.irq};
		end else if (index == FDC_IDX_DMA) begin
			value = {5'h00, cfg.dma};
		end else if (index == FDC_IDX_MODE) begin
			value = cfg.mode & 8'h9f;
		end else if (index == FDC_IDX_KIND) begin
			value = {6'h00, cfg.kind};
		end else if (index == FDC_IDX_SELECT) begin
			value = {3'h0, cfg.rate_tbl, 1'b0, cfg.drv_type};
		end
	end
endmodule : fdc_readback
`default_nettype wire

// File: fdc_write_protect.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_write_protect (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Pin and override
	input wire logic wp_pin_n,
	input wire logic force_protect,
	// Result
	output logic protected_reg
);
	logic wp_meta_reg;
	logic wp_sync_reg;

	// Pin is asynchronous to clk_sys, so two flops first
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wp_meta_reg <= 1'b1;
			wp_sync_reg <= 1'b1;
		end else begin
			wp_meta_reg <= wp_pin_n;
			wp_sync_reg <= wp_meta_reg;
		end
	end

	// Override wins; otherwise the low pin protects
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			protected_reg <= 1'b0;
		end else begin
			protected_reg <= force_protect | ~wp_sync_reg;
		end
	end
endmodule : fdc_write_protect
`default_nettype wire

// File: fdc_config_bank.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_config_bank
	import fdc_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Write-protect pin, active low
	input wire logic write_protect_pin_n,
	// Device settings
	output logic floppy_enable,
	output logic [15:0] io_base,
	output logic [3:0] interrupt_channel_select,
	output logic [2:0] dma_channel_select,
	// Mode settings
	output logic software_power_down,
	output logic forced_write_protect,
	output logic media_write_protected,
	output var fdc_pkg::fdc_personality_t personality,
	output logic personality_reserved,
	output logic dma_burst_select,
	output logic dma_burst_enable,
	output logic three_mode_drive_enable,
	// Drive settings
	output logic [1:0] drive_kind,
	output logic [1:0] rate_table_select,
	output logic [1:0] drive_type_select,
	// Derived status
	output logic controller_active,
	output logic config_update
);
	import fdc_pkg::*;

	// Stored fields, shared with the readback module
	fdc_cfg_if cfg ();

	logic enable_reg;
	logic [7:0] base_hi_reg;
	logic [7:0] base_lo_reg;
	logic [3:0] irq_reg;
	logic [2:0] dma_reg;
	logic pwrdn_reg;
	logic force_wp_reg;
	logic [1:0] ifmode_reg;
	logic dma_mode_reg;
	logic three_reg;
	logic [1:0] kind_reg;
	logic [1:0] rate_tbl_reg;
	logic [1:0] drv_type_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic update_reg;
	logic active_reg;
	logic burst_reg;
	logic rsvd_mode_reg;
	logic wp_reg;

	// Write strobes, one per index
	logic wr_enable;
	logic wr_base_hi;
	logic wr_base_lo;
	logic wr_irq;
	logic wr_dma;
	logic wr_mode;
	logic wr_kind;
	logic wr_select;

	// Index decode for writes
	always_comb begin
		wr_enable = 1'b0;
		wr_base_hi = 1'b0;
		wr_base_lo = 1'b0;
		wr_irq = 1'b0;
		wr_dma = 1'b0;
		wr_mode = 1'b0;
		wr_kind = 1'b0;
		wr_select = 1'b0;
		if (!reg_wr) begin
			wr_enable = 1'b0;
		end else if (reg_addr == FDC_IDX_ENABLE) begin
			wr_enable = 1'b1;
		end else if (reg_addr == FDC_IDX_BASE_HI) begin
			wr_base_hi = 1'b1;
		end else if (reg_addr == FDC_IDX_BASE_LO) begin
			wr_base_lo = 1'b1;
		end else if (reg_addr == FDC_IDX_IRQ) begin
			wr_irq = 1'b1;
		end else if (reg_addr == FDC_IDX_DMA) begin
			wr_dma = 1'b1;
		end else if (reg_addr == FDC_IDX_MODE) begin
			wr_mode = 1'b1;
		end else if (reg_addr == FDC_IDX_KIND) begin
			wr_kind = 1'b1;
		end else if (reg_addr == FDC_IDX_SELECT) begin
			wr_select = 1'b1;
		end
	end

	// Device enable; only bit 0 is stored
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			enable_reg <= FDC_RST_ENABLE[FDC_POS_ENABLE];
		end else if (wr_enable) begin
			enable_reg <= reg_wdata[FDC_POS_ENABLE];
		end
	end

	// Base address bytes, full width writable
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			base_hi_reg <= FDC_RST_BASE_HI;
			base_lo_reg <= FDC_RST_BASE_LO;
		end else begin
			if (wr_base_hi) begin
				base_hi_reg <= reg_wdata;
			end
			if (wr_base_lo) begin
				base_lo_reg <= reg_wdata;
			end
		end
	end

	// Resource channels; upper bits dropped on write
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			irq_reg <= FDC_RST_IRQ;
			dma_reg <= FDC_RST_DMA;
		end else begin
			if (wr_irq) begin
				irq_reg <= reg_wdata[3:0];
			end
			if (wr_dma) begin
				dma_reg <= reg_wdata[2:0];
			end
		end
	end

	// Mode fields; bits 6-5 are not stored at all
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pwrdn_reg <= FDC_RST_MODE[FDC_POS_PWRDN];
			force_wp_reg <= FDC_RST_MODE[FDC_POS_FORCE_WP];
			ifmode_reg <= FDC_RST_MODE[FDC_POS_IFMODE +: 2];
			dma_mode_reg <= FDC_RST_MODE[FDC_POS_DMA_MODE];
			three_reg <= FDC_RST_MODE[FDC_POS_THREE];
		end else if (wr_mode) begin
			pwrdn_reg <= reg_wdata[FDC_POS_PWRDN];
			force_wp_reg <= reg_wdata[FDC_POS_FORCE_WP];
			ifmode_reg <= reg_wdata[FDC_POS_IFMODE +: 2];
			dma_mode_reg <= reg_wdata[FDC_POS_DMA_MODE];
			three_reg <= reg_wdata[FDC_POS_THREE];
		end
	end

	// Drive kind and selection fields
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			kind_reg <= FDC_RST_KIND;
			rate_tbl_reg <= FDC_RST_RATE_TBL;
			drv_type_reg <= FDC_RST_DRV_TYPE;
		end else begin
			if (wr_kind) begin
				kind_reg <= reg_wdata[1:0];
			end
			if (wr_select) begin
				rate_tbl_reg <= reg_wdata[FDC_POS_RATE_TBL +: 2];
				drv_type_reg <= reg_wdata[FDC_POS_DRV_TYPE +: 2];
			end
		end
	end

	// Publish stored fields; reserved mode bits are zero
	assign cfg.enable = enable_reg;
	assign cfg.base_hi = base_hi_reg;
	assign cfg.base_lo = base_lo_reg;
	assign cfg.irq = irq_reg;
	assign cfg.dma = dma_reg;
	assign cfg.mode = {pwrdn_reg, 2'b00, force_wp_reg, ifmode_reg, dma_mode_reg, three_reg};
	assign cfg.kind = kind_reg;
	assign cfg.rate_tbl = rate_tbl_reg;
	assign cfg.drv_type = drv_type_reg;

	// Read value for the current index
	fdc_readback u_readback (
		.cfg(cfg),
		.index(reg_addr),
		.value(rdata_next)
	);

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	// Pulse after any write that lands on a mapped index
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			update_reg <= 1'b0;
		end else begin
			update_reg <= reg_wr & fdc_is_mapped(reg_addr);
		end
	end

	// Pin merge, with the pin synchronised inside
	fdc_write_protect u_write_protect (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.wp_pin_n(write_protect_pin_n),
		.force_protect(force_wp_reg),
		.protected_reg(wp_reg)
	);

	// Derived controls, registered so outputs come from flops
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			active_reg <= 1'b0;
			burst_reg <= 1'b0;
			rsvd_mode_reg <= 1'b0;
		end else begin
			// Power-down overrides an enabled device
			active_reg <= enable_reg & ~pwrdn_reg;
			// Bit low means burst transfers
			burst_reg <= ~dma_mode_reg;
			// Code 10 has no defined personality
			rsvd_mode_reg <= (ifmode_reg == FDC_IF_RSVD);
		end
	end

	// Outputs straight from storage
	assign reg_rdata = rdata_reg;
	assign floppy_enable = enable_reg;
	assign io_base = {base_hi_reg, base_lo_reg};
	assign interrupt_channel_select = irq_reg;
	assign dma_channel_select = dma_reg;
	assign software_power_down = pwrdn_reg;
	assign forced_write_protect = force_wp_reg;
	assign media_write_protected = wp_reg;
	assign personality = fdc_personality_t'(ifmode_reg);
	assign personality_reserved = rsvd_mode_reg;
	assign dma_burst_select = dma_mode_reg;
	assign dma_burst_enable = burst_reg;
	assign three_mode_drive_enable = three_reg;
	assign drive_kind = kind_reg;
	assign rate_table_select = rate_tbl_reg;
	assign drive_type_select = drv_type_reg;
	assign controller_active = active_reg;
	assign config_update = update_reg;
endmodule : fdc_config_bank
`default_nettype wire

// File: fdc_bank_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Timing relations between the register port and the settings outputs
module fdc_bank_props
	import fdc_pkg::*;
(
	// Clock, reset and register port
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Watched settings
	input wire logic floppy_enable,
	input wire logic [15:0] io_base,
	input wire logic [3:0] interrupt_channel_select,
	input wire logic [2:0] dma_channel_select,
	input wire logic software_power_down,
	input wire logic forced_write_protect,
	input wire logic media_write_protected,
	input wire logic dma_burst_select,
	input wire logic dma_burst_enable,
	input wire logic controller_active
);
	// One domain, so clock and reset are given once
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	idle_read_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside read cycle");
	base_high_a: assert property (reg_wr && reg_addr == FDC_IDX_BASE_HI |=>
		io_base[15:8] == $past(reg_wdata)) else $error("upper base byte not stored");
	base_low_a: assert property (reg_wr && reg_addr == FDC_IDX_BASE_LO |=>
		io_base[7:0] == $past(reg_wdata)) else $error("lower base byte not stored");
	irq_field_a: assert property (reg_wr && reg_addr == FDC_IDX_IRQ |=>
		interrupt_channel_select == $past(reg_wdata[3:0])) else $error("irq field wrong");
	dma_field_a: assert property (reg_wr && reg_addr == FDC_IDX_DMA |=>
		dma_channel_select == $past(reg_wdata[2:0])) else $error("dma field wrong");
	power_down_a: assert property (reg_wr && reg_addr == FDC_IDX_MODE |=>
		software_power_down == $past(reg_wdata[7])) else $error("power-down bit wrong");
	force_wp_a: assert property (forced_write_protect |=> media_write_protected)
		else $error("forced protect not applied");
	burst_inv_a: assert property (dma_burst_enable == !$past(dma_burst_select))
		else $error("burst enable not inverse of select");
	enable_hold_a: assert property (!(reg_wr && reg_addr == FDC_IDX_ENABLE) |=>
		$stable(floppy_enable)) else $error("enable changed without write");
	// First edge after reset still shows the reset value of the registered flag
	active_state_a: assert property ($past(nrst) |-> controller_active ==
		($past(floppy_enable) && !$past(software_power_down))) else $error("active state wrong");
	// Main scenarios
	cover property (reg_wr && reg_addr == FDC_IDX_MODE && reg_wdata[7]);
	cover property (media_write_protected && !forced_write_protect);
	cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule : fdc_bank_props
`default_nettype wire

// File: test_floppy_controller_config.sv
`timescale 1ns/1ps
`default_nettype none
module test_floppy_controller_config;
	import fdc_pkg::*;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic wp_n = 1'b1;
	logic [7:0] reg_rdata;
	logic floppy_enable, software_power_down, forced_write_protect, media_write_protected;
	logic personality_reserved, dma_burst_select, dma_burst_enable, three_mode_drive_enable;
	logic controller_active, config_update;
	logic [15:0] io_base;
	logic [3:0] interrupt_channel_select;
	logic [2:0] dma_channel_select;
	logic [1:0] drive_kind, rate_table_select, drive_type_select;
	fdc_personality_t personality;
	int n_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	integer seed = 54734;
	// Reference model: one byte per index, writable bits per index
	logic [7:0] mdl [0:255];
	logic [7:0] idx [0:7] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h74, 8'hf0, 8'hf2, 8'hf4};
	logic [7:0] rst_val [0:7] = '{8'h01, 8'h03, 8'hf0, 8'h06, 8'h02, 8'h0e, 8'h03, 8'h00};
	logic [7:0] wmask [0:7] = '{8'h01, 8'hff, 8'hff, 8'h0f, 8'h07, 8'h9f, 8'h03, 8'h1b};
	always #4 clk_sys = ~clk_sys;
	fdc_config_bank uut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.write_protect_pin_n(wp_n), .floppy_enable(floppy_enable), .io_base(io_base),
		.interrupt_channel_select(interrupt_channel_select),
		.dma_channel_select(dma_channel_select), .software_power_down(software_power_down),
		.forced_write_protect(forced_write_protect), .media_write_protected(media_write_protected),
		.personality(personality), .personality_reserved(personality_reserved),
		.dma_burst_select(dma_burst_select), .dma_burst_enable(dma_burst_enable),
		.three_mode_drive_enable(three_mode_drive_enable), .drive_kind(drive_kind),
		.rate_table_select(rate_table_select), .drive_type_select(drive_type_select),
		.controller_active(controller_active), .config_update(config_update));
	// Writable bits of an index; zero marks an unmapped index
	function automatic logic [7:0] msk(input logic [7:0] a);
		msk = 8'h00;
		for (int i = 0; i < 8; i++)
			if (idx[i] == a) msk = wmask[i];
	endfunction : msk
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wrap_up();
		$display("Checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	// One bus cycle; strobes stay up so cycles can run back to back
	task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		#1;
		if (w) begin
			chk("config_update", msk(a) != 8'h00, config_update);
			mdl[a] = (mdl[a] & ~msk(a)) | (d & msk(a));
		end else
			chk("reg_rdata", mdl[a] & msk(a), reg_rdata);
	endtask : op
	task automatic idle(input int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : idle
	// Every output except reg_rdata and config_update against the model; pin sync needs 3 quiet edges first
	task automatic outs();
		chk("enable", mdl[8'h30][0], floppy_enable);
		chk("io_base", {mdl[8'h60], mdl[8'h61]}, io_base);
		chk("irq", mdl[8'h70][3:0], interrupt_channel_select);
		chk("dma", mdl[8'h74][2:0], dma_channel_select);
		chk("power_down", mdl[8'hf0][7], software_power_down);
		chk("active", mdl[8'h30][0] & !mdl[8'hf0][7], controller_active);
		chk("force_wp", mdl[8'hf0][4], forced_write_protect);
		chk("media_wp", mdl[8'hf0][4] | !wp_n, media_write_protected);
		chk("personality", mdl[8'hf0][3:2], personality);
		chk("pers_rsvd", mdl[8'hf0][3:2] == 2'b10, personality_reserved);
		chk("burst_sel", mdl[8'hf0][1], dma_burst_select);
		chk("burst_en", !mdl[8'hf0][1], dma_burst_enable);
		chk("three_mode", mdl[8'hf0][0], three_mode_drive_enable);
		chk("kind", mdl[8'hf2][1:0], drive_kind);
		chk("rate_tbl", mdl[8'hf4][4:3], rate_table_select);
		chk("drv_type", mdl[8'hf4][1:0], drive_type_select);
	endtask : outs
	// Reset, then read every index and one unmapped index back to back
	task automatic reset_read();
		wp_n <= 1'b1;
		nrst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		nrst <= 1'b1;
		for (int i = 0; i < 256; i++)
			mdl[i] = 8'h00;
		for (int i = 0; i < 8; i++)
			mdl[idx[i]] = rst_val[i];
		@(posedge clk_sys);
		#1;
		outs();
		for (int i = 0; i < 8; i++)
			op(1'b0, idx[i], 8'h00);
		op(1'b0, 8'h31, 8'h00);
		idle(1);
		$display("Reset values done");
	endtask : reset_read
	initial begin
		logic [7:0] a;
		logic [7:0] d;
		reset_read();
		// Random writes, some unmapped, each read back in the next cycle
		for (int i = 0; i < 60; i++) begin
			a = ($random(seed) & 3) == 0 ? 8'($random(seed)) : idx[$random(seed) & 7];
			d = 8'($random(seed));
			wp_n <= 1'($random(seed));
			op(1'b1, a, d);
			op(1'b0, a, 8'h00);
			idle(4);
			outs();
		end
		$display("Random writes done");
		// Every personality code, burst select cleared
		for (int p = 0; p < 4; p++) begin
			op(1'b1, FDC_IDX_MODE, 8'(p * 4));
			idle(2);
			outs();
		end
		$display("Personality codes done");
		// Forced protect with pin left as the random loop set it, then pin low alone, then power-down
		op(1'b1, FDC_IDX_MODE, 8'h10);
		idle(3);
		outs();
		wp_n <= 1'b0;
		op(1'b1, FDC_IDX_MODE, 8'h00);
		idle(4);
		outs();
		op(1'b1, FDC_IDX_MODE, 8'h80);
		idle(2);
		outs();
		$display("Protect and power-down done");
		reset_read();
		wrap_up();
	end
	// Hang guard
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors++;
			wrap_up();
		end
	end
endmodule : test_floppy_controller_config
bind fdc_config_bank fdc_bank_props u_props (.clk_sys(clk_sys), .nrst(nrst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .floppy_enable(floppy_enable), .io_base(io_base),
	.interrupt_channel_select(interrupt_channel_select),
	.dma_channel_select(dma_channel_select), .software_power_down(software_power_down),
	.forced_write_protect(forced_write_protect), .media_write_protected(media_write_protected),
	.dma_burst_select(dma_burst_select), .dma_burst_enable(dma_burst_enable),
	.controller_active(controller_active));
`default_nettype wire
